// file: logic/shc_host_port.sv
// serial host port, register protection, gpio pins, clock output and stop control
// How it works
// - select pin high makes pin0 an active-low chip select, else gpio
// - serial port active when select high; i2c flagged when both selects low
// - pin0 and pin1 levels caught at reset release as i2c address bits
// - divider field picks system clock over 2, 4, 8 or 16
// - clock output off: divider ignored, pin1 run from gpio register
// - io control writes ignored unless locker was just given unlock code
// - any write to any address relocks protection
// - select, oscillator enables and stop bit writable only in can reset mode
// - select 1 picks external oscillator; switching only with both running
// - oscillator feeding system clock when a write arrives is never disabled by that write
// - stop bit drives 16 more clock pulses, then oscillators off
// - pin1 rests low during stop mode
// - wake restarts both oscillators whatever their enables were
// - serial or can wake ends stop; writing zero to stop does nothing
// - gpio enable 1 drives data bit, 0 latches pin into input bit
// - pin0 data only with select low, pin1 data only with clock output off
// - modes 0 and 3 only: sample on rising, shift on falling clock
// - msb first; first byte instruction, second byte address
// - read 0x23, write 0x22, bit modify 0x25
// - read shifts out addressed data, address plus one per byte
// - write stores each byte then advances the address
// - bit modify is four bytes on one register, no increment
// - bit modify changes only the masked bits
`timescale 1ns/10ps
module shc_host_port (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            interfaceSelectPin,
	input  wire logic            interfaceSelectPinB,
	input  wire logic            serialClockIn,
	input  wire logic            serialDataIn,
	output logic                 serialDataOut,
	output logic                 serialDataOutEn,
	input  wire logic            serialChipSelectN,
	output logic                 pin0Out,
	output logic                 pin0OutEn,
	input  wire logic            clockoutPinIn,
	output logic                 clockoutPinOut,
	output logic                 clockoutPinOutEn,
	input  wire logic            canResetMode,
	input  wire logic            canWakeIn,
	input  wire logic            i2cWake,
	output logic                 hostSpiActive,
	output logic                 hostI2cActive,
	output logic [1:0]           i2cAddressLow,
	output logic                 systemClockSourceSelect,
	output logic                 externalOscRun,
	output logic                 internalOscRun,
	output logic                 stopMode,
	output shc_pkg::shc_wr_t     regWrite,
	output logic [7:0]           regReadAddr,
	input  wire logic [7:0]      regReadData
);
	import shc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; chip select idles high after reset
	logic [6:0] pinS;
	shc_sync #(.W(7), .RESET_VAL(7'h10)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({canWakeIn, interfaceSelectPinB, serialChipSelectN, serialClockIn,
		       serialDataIn, clockoutPinIn, interfaceSelectPin}),
		.q   (pinS)
	);
	wire msel0S  = pinS[0];
	wire p1S     = pinS[1];
	wire siS     = pinS[2];
	wire sckS    = pinS[3];
	wire csS     = pinS[4];
	wire msel1S  = pinS[5];
	wire canWkS  = pinS[6];

	////////////////////////////////////////////////////////////////////////
	// state
	logic       sckD, csD;
	logic [2:0] bitCnt;
	logic [6:0] shiftIn;
	logic [7:0] instr, addr, mask, txShift;
	logic       loadPending, loadNow;
	shc_spi_t   state, next_state;
	logic       locked;
	logic       cko, system_clock_source_select, xEn, iEn, stopBit;
	logic [1:0] clock_output_divider;
	logic [4:0] pulseCnt;
	logic       p1Oe, p0Oe, p1Out, p0Out, p1In, p0In;
	logic [1:0] idCnt;
	logic       ckLevel, ckRise;
	logic       wrGo;
	logic [7:0] wrData;

	////////////////////////////////////////////////////////////////////////
	// edge detection on the synchronised serial pins
	wire sckRise   = sckS && !sckD;
	wire sckFall   = !sckS && sckD;
	wire csFall    = csD && !csS;
	wire spiOn     = msel0S;
	wire selActive = spiOn && !csS;
	wire byteDone  = selActive && sckRise && (bitCnt == 3'h7);
	wire [7:0] rxByte = {shiftIn, siS};
	wire isRead    = (instr == INS_READ);
	wire knownIns  = (rxByte == INS_READ) || (rxByte == INS_WRITE) || (rxByte == INS_MODIFY);

	////////////////////////////////////////////////////////////////////////
	// register views
	function automatic logic [7:0] pick(input logic [7:0] a, input logic [7:0] io,
	                                   input logic [7:0] gp, input logic [7:0] ext);
		logic [7:0] r;
		r = ext;
		if (a == ADDR_IO_CLOCK_CONTROL)
			r = io;
		else if (a == ADDR_GPIO)
			r = gp;
		else if (a == ADDR_LOCK)
			r = 8'h00;                                       // locker is write only
		return r;
	endfunction

	wire [7:0] ioView  = {cko, clock_output_divider, 1'b0, system_clock_source_select, xEn, iEn, stopBit};
	wire [7:0] gpRead  = {2'b00, p1Oe, p0Oe, 2'b00, p1In, p0In};
	wire [7:0] gpStore = {2'b00, p1Oe, p0Oe, 2'b00, p1Out, p0Out};
	wire [7:0] rdData  = pick(addr, ioView, gpRead, regReadData);
	// modify works on stored output bits, not on the sampled inputs
	wire [7:0] modBase = pick(addr, ioView, gpStore, regReadData);

	////////////////////////////////////////////////////////////////////////
	// serial engine next state and write generation
	always_comb begin
		next_state = state;
		wrGo       = 1'b0;
		wrData     = rxByte;
		if (byteDone) begin
			unique case (state)
				SP_INSTR: begin
					next_state = knownIns ? SP_ADDR : SP_IGNORE;
				end
				SP_ADDR: begin
					next_state = (instr == INS_MODIFY) ? SP_MASK : SP_DATA;
				end
				SP_DATA: begin
					wrGo = (instr == INS_WRITE);
				end
				SP_MASK: begin
					next_state = SP_MODIFY;
				end
				SP_MODIFY: begin
					next_state = SP_DONE;
					wrGo       = 1'b1;
					wrData     = (modBase & ~mask) | (rxByte & mask);
				end
				SP_DONE, SP_IGNORE: begin
					next_state = state;
				end
				default: begin
					next_state = SP_IGNORE;
				end
			endcase
		end
	end

	// deselect returns the engine to the instruction byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state   <= SP_INSTR;
			bitCnt  <= 3'h0;
			shiftIn <= 7'h00;
			sckD    <= 1'b0;
			csD     <= 1'b1;
		end else begin
			sckD <= sckS;
			csD  <= csS;
			if (!selActive) begin
				state  <= SP_INSTR;
				bitCnt <= 3'h0;
			end else begin
				state <= next_state;
				if (sckRise) begin
					shiftIn <= rxByte[6:0];
					bitCnt  <= bitCnt + 3'h1;
				end
			end
		end
	end

	// instruction, address and mask capture; read data shifting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr       <= 8'h00;
			addr        <= 8'h00;
			mask        <= 8'h00;
			loadPending <= 1'b0;
			loadNow     <= 1'b0;
			txShift     <= 8'h00;
		end else begin
			loadPending <= 1'b0;
			// outside read data follows regReadAddr, itself a clock behind addr
			loadNow     <= loadPending;
			if (byteDone && state == SP_INSTR)
				instr <= rxByte;
			if (byteDone && state == SP_ADDR) begin
				addr        <= rxByte;
				loadPending <= isRead;
			end
			if (byteDone && state == SP_DATA) begin
				addr        <= addr + 8'h01;
				loadPending <= isRead;
			end
			if (byteDone && state == SP_MASK)
				mask <= rxByte;
			if (loadNow)
				txShift <= rdData;
			else if (sckFall && state == SP_DATA && isRead)
				txShift <= {txShift[6:0], 1'b0};
		end
	end

	// output data changes on the falling serial clock only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serialDataOut   <= 1'b0;
			serialDataOutEn <= 1'b0;
			regWrite        <= '0;
			regReadAddr     <= 8'h00;
		end else begin
			if (selActive && sckFall && state == SP_DATA && isRead)
				serialDataOut <= txShift[7];
			serialDataOutEn <= selActive && state == SP_DATA && isRead;
			regWrite        <= '{en: wrGo, addr: addr, data: wrData};
			regReadAddr     <= addr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// protection and io control decode
	wire isIoWr   = regWrite.en && regWrite.addr == ADDR_IO_CLOCK_CONTROL;
	wire ioWrOk   = isIoWr && !locked;
	wire cfgOk    = ioWrOk && canResetMode;
	wire bothOn   = xEn && iEn;
	wire wakeEv   = stopBit && (canWkS || i2cWake || (spiOn && csFall));
	wire next_system_clock_source_select = (cfgOk && bothOn) ? regWrite.data[B_SYSTEM_CLOCK_SOURCE_SELECT] : system_clock_source_select;
	wire next_xEn = cfgOk ? (regWrite.data[B_EXTERNAL_OSC_ENABLE] || system_clock_source_select) : xEn;
	wire next_iEn = cfgOk ? (regWrite.data[B_INTERNAL_OSC_ENABLE] || !system_clock_source_select) : iEn;
	wire stopSet  = cfgOk && regWrite.data[B_STOP];

	// any write relocks; only the unlock code to the locker opens it
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			locked <= 1'b1;
		else if (regWrite.en)
			locked <= !(regWrite.addr == ADDR_LOCK && regWrite.data == UNLOCK_CODE);
	end

	// io control register, stop sequence and wake
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cko      <= IO_CLOCK_CONTROL_RESET[B_CLOCK_OUTPUT_ENABLE];
			clock_output_divider   <= IO_CLOCK_CONTROL_RESET[B_CKSEL+:2];
			system_clock_source_select   <= IO_CLOCK_CONTROL_RESET[B_SYSTEM_CLOCK_SOURCE_SELECT];
			xEn      <= IO_CLOCK_CONTROL_RESET[B_EXTERNAL_OSC_ENABLE];
			iEn      <= IO_CLOCK_CONTROL_RESET[B_INTERNAL_OSC_ENABLE];
			stopBit  <= IO_CLOCK_CONTROL_RESET[B_STOP];
			stopMode <= 1'b0;
			pulseCnt <= 5'h00;
		end else begin
			if (ioWrOk) begin
				cko    <= regWrite.data[B_CLOCK_OUTPUT_ENABLE];
				clock_output_divider <= regWrite.data[B_CKSEL+:2];
			end
			system_clock_source_select <= next_system_clock_source_select;
			if (wakeEv) begin
				xEn      <= 1'b1;
				iEn      <= 1'b1;
				stopBit  <= 1'b0;
				stopMode <= 1'b0;
				pulseCnt <= 5'h00;
			end else begin
				xEn <= next_xEn;
				iEn <= next_iEn;
				if (stopSet)
					stopBit <= 1'b1;
				// last pulse runs to its falling edge, so no short pulse before the pin parks low
				if (stopBit && !stopMode && ckRise && pulseCnt != STOP_PULSES)
					pulseCnt <= pulseCnt + 5'h01;
				if (stopBit && !stopMode && pulseCnt == STOP_PULSES && !ckLevel)
					stopMode <= 1'b1;
			end
		end
	end

	// divider keeps running for the stop pulses even with the pin in gpio use
	shc_clock_divider u_div (
		.clk   (clk),
		.rst   (rst),
		.run   (!stopMode),
		.sel   (clock_output_divider),
		.level (ckLevel),
		.rise  (ckRise)
	);

	////////////////////////////////////////////////////////////////////////
	// gpio register and input latching
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{p1Oe, p0Oe} <= {GPIO_RESET[B_P1OE], GPIO_RESET[B_P0OE]};
			{p1Out, p0Out} <= {GPIO_RESET[B_P1D], GPIO_RESET[B_P0D]};
			p1In <= 1'b0;
			p0In <= 1'b0;
		end else begin
			if (regWrite.en && regWrite.addr == ADDR_GPIO) begin
				p1Oe  <= regWrite.data[B_P1OE];
				p0Oe  <= regWrite.data[B_P0OE];
				p1Out <= regWrite.data[B_P1D];
				p0Out <= regWrite.data[B_P0D];
			end
			if (!p0Oe && !msel0S)
				p0In <= csS;
			if (!p1Oe && !cko)
				p1In <= p1S;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers and status outputs
	wire next_p0En  = !msel0S && p0Oe;
	wire next_p1En  = stopMode || cko || p1Oe;
	wire next_p1Out = stopMode ? 1'b0 : (cko ? ckLevel : p1Out);

	// address bits wait two clocks so the synchronisers hold real pin levels
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin0Out                 <= 1'b0;
			pin0OutEn               <= 1'b0;
			clockoutPinOut          <= 1'b0;
			clockoutPinOutEn        <= 1'b0;
			hostSpiActive           <= 1'b0;
			hostI2cActive           <= 1'b0;
			systemClockSourceSelect <= 1'b0;
			externalOscRun          <= 1'b0;
			internalOscRun          <= 1'b0;
			i2cAddressLow           <= 2'b00;
			idCnt                   <= 2'h0;
		end else begin
			pin0Out                 <= p0Out;
			pin0OutEn               <= next_p0En;
			clockoutPinOut          <= next_p1Out;
			clockoutPinOutEn        <= next_p1En;
			hostSpiActive           <= spiOn;
			hostI2cActive           <= !msel0S && !msel1S;
			systemClockSourceSelect <= system_clock_source_select;
			externalOscRun          <= xEn && !stopMode;
			internalOscRun          <= iEn && !stopMode;
			if (idCnt != 2'h3)
				idCnt <= idCnt + 2'h1;
			if (idCnt == 2'h2)
				i2cAddressLow <= {p1S, csS};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	locked_io_a: assert property (@(posedge clk) disable iff (rst)
		isIoWr && locked |=> {cko, clock_output_divider} == $past({cko, clock_output_divider}))
		else $error("io control changed while locked");
	relock_any_a: assert property (@(posedge clk) disable iff (rst)
		regWrite.en && !(regWrite.addr == ADDR_LOCK && regWrite.data == UNLOCK_CODE) |=> locked)
		else $error("protection not relocked after a write");
	run_mode_a: assert property (@(posedge clk) disable iff (rst)
		isIoWr && !canResetMode && !wakeEv |=> $stable(system_clock_source_select) && $stable(xEn) && $stable(iEn))
		else $error("clock config changed outside reset mode");
	sel_osc_on_a: assert property (@(posedge clk) disable iff (rst)
		system_clock_source_select ? xEn : iEn)
		else $error("selected oscillator disabled");
	stop_pin_low_a: assert property (@(posedge clk) disable iff (rst)
		stopMode ##1 stopMode |-> !clockoutPinOut && clockoutPinOutEn)
		else $error("pin1 not low in stop mode");
	wake_restart_a: assert property (@(posedge clk) disable iff (rst)
		stopMode && wakeEv |=> xEn && iEn && !stopBit ##1 externalOscRun && internalOscRun)
		else $error("wake did not restart oscillators");
	zero_stop_a: assert property (@(posedge clk) disable iff (rst)
		stopBit && !wakeEv |=> stopBit)
		else $error("stop bit cleared without wake");
	stop_count_a: assert property (@(posedge clk) disable iff (rst)
		$rose(stopMode) |-> $past(pulseCnt) == STOP_PULSES)
		else $error("stop entered before sixteen pulses");
	cs_pin_a: assert property (@(posedge clk) disable iff (rst)
		msel0S |=> !pin0OutEn)
		else $error("pin0 driven while used as chip select");
	unknown_quiet_a: assert property (@(posedge clk) disable iff (rst)
		state == SP_IGNORE |=> !serialDataOutEn && !regWrite.en)
		else $error("activity after unknown instruction");

endmodule // shc_host_port

// file: logic/shc_pkg.sv
// shared constants and types of the host port and pin/clock control
package shc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [7:0] ADDR_IO_CLOCK_CONTROL  = 8'h78;
	localparam logic [7:0] ADDR_GPIO   = 8'h79;
	localparam logic [7:0] ADDR_LOCK   = 8'h7f;
	localparam logic [7:0] UNLOCK_CODE = 8'ha6;
	localparam logic [7:0] IO_CLOCK_CONTROL_RESET = 8'h86;
	localparam logic [7:0] GPIO_RESET  = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// io_clock_control field positions
	localparam int B_CLOCK_OUTPUT_ENABLE  = 7;
	localparam int B_CKSEL  = 5;
	localparam int B_SYSTEM_CLOCK_SOURCE_SELECT = 3;
	localparam int B_EXTERNAL_OSC_ENABLE = 2;
	localparam int B_INTERNAL_OSC_ENABLE = 1;
	localparam int B_STOP   = 0;

	// gpio_control field positions
	localparam int B_P1OE = 5;
	localparam int B_P0OE = 4;
	localparam int B_P1D  = 1;
	localparam int B_P0D  = 0;

	////////////////////////////////////////////////////////////////////////
	// serial instructions
	localparam logic [7:0] INS_READ   = 8'h23;
	localparam logic [7:0] INS_WRITE  = 8'h22;
	localparam logic [7:0] INS_MODIFY = 8'h25;

	// clock pulses driven out after the stop bit is set
	localparam logic [4:0] STOP_PULSES = 5'h10;

	////////////////////////////////////////////////////////////////////////
	// serial engine states, gray along instruction/address/data
	typedef enum logic [2:0] {
		SP_INSTR  = 3'b000,
		SP_ADDR   = 3'b001,
		SP_DATA   = 3'b011,
		SP_MASK   = 3'b010,
		SP_MODIFY = 3'b110,
		SP_DONE   = 3'b111,
		SP_IGNORE = 3'b101
	} shc_spi_t;

	// one register write toward the register space
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} shc_wr_t;

endpackage

// file: logic/shc_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module shc_sync #(
	parameter int          W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // shc_sync

// file: logic/shc_clock_divider.sv
// clock output divider: half period of 1, 2, 4 or 8 system clocks
`timescale 1ns/10ps
module shc_clock_divider (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [1:0] sel,
	output logic            level,
	output logic            rise
);
	logic [2:0] count;
	wire  [2:0] lastCount = 3'((4'h1 << sel) - 4'h1);
	wire        flip      = run && (count >= lastCount);

	// output is registered, so the fastest setting toggles every clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 3'h0;
			level <= 1'b0;
			rise  <= 1'b0;
		end else begin
			count <= (!run || flip) ? 3'h0 : count + 3'h1;
			level <= run ? (level ^ flip) : 1'b0;
			rise  <= flip && !level;
		end
	end
endmodule // shc_clock_divider

// file: test/shc_spi_master.sv
// serial host model: mode 0 or mode 3 master that frames bytes toward the host port
`timescale 1ns/10ps
module shc_spi_master (
	input  wire logic clk,
	output logic      sck,
	output logic      mosi,
	output logic      csN,
	input  wire logic miso
);
	// six clocks a half bit leaves margin over the port's pin oversampling
	localparam int HALF = 6;
	// clock idle level: 0 for mode 0, 1 for mode 3
	logic cpol = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// idle levels: clock stands low before the first frame, chip select high
	initial begin
		sck  = 1'b0;
		mosi = 1'b1;
		csN  = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// one byte msb first: change data with the clock low, sample on the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck  <= 1'b0;
			mosi <= tx[i];
			repeat (HALF) @(posedge clk);
			sck <= 1'b1;
			rx[i] = miso;
			repeat (HALF) @(posedge clk);
		end
	endtask

	// idle level of the clock picks mode 0 or mode 3; only changed between frames
	task automatic set_mode(input logic pol);
		cpol = pol;
		sck  <= pol;
		repeat (2 * HALF) @(posedge clk);
	endtask

	// chip select fall opens a frame; the first byte is the instruction
	task automatic begin_frame();
		csN <= 1'b0;
		repeat (2 * HALF) @(posedge clk);
	endtask

	// released data line toggles so a stale level cannot pass for a bit
	task automatic end_frame();
		sck <= cpol;
		repeat (HALF) @(posedge clk);
		csN  <= 1'b1;
		mosi <= ~mosi;
		repeat (4 * HALF) @(posedge clk);
	endtask
endmodule // shc_spi_master

// file: test/tb_shc_host_port.sv
// bench of the serial host port: register access, pins, divider and stop
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_shc_host_port;
	import shc_pkg::*;
	logic       clk;
	logic       rst          = 1'b1;
	logic       selPin       = 1'b1;
	logic       canResetMode = 1'b0;
	logic       canWakeIn    = 1'b0;
	logic       selPinB      = 1'b0;
	logic       i2cWake      = 1'b0;
	logic       pinDrive     = 1'b1;
	logic       sdoSeen      = 1'b0;
	logic       coPrev       = 1'b0;
	logic       sck, mosi, csN, sdo, sdoEn, p0Out, p0En, coOut, coEn;
	logic       spiAct, i2cAct, system_clock_source_select, xRun, iRun, stopMode;
	logic [1:0] i2cAddr;
	logic [1:0] ioWrDly = 2'b00;
	logic [7:0] rdAddr;
	logic [7:0] rx [5];
	logic [7:0] oscW [5] = '{8'he4, 8'hee, 8'hea, 8'hec, 8'he4};
	logic [7:0] oscE [5] = '{8'he6, 8'hee, 8'hee, 8'hec, 8'hec};
	shc_wr_t    regWrite;
	shc_wr_t    wrLog [$];
	int         errors, cmpCount, sinceRise, lastPeriod, riseCount, riseBase;
	// shared pins resolve from every driver; the data output has a pull-up
	wire        csWire  = p0En ? p0Out : csN;
	wire        coWire  = coEn ? coOut : pinDrive;
	wire        sdoWire = sdoEn ? sdo : 1'b1;

	shc_host_port i_shc_host_port (
		.clk(clk), .rst(rst), .interfaceSelectPin(selPin), .interfaceSelectPinB(selPinB),
		.serialClockIn(sck), .serialDataIn(mosi), .serialDataOut(sdo), .serialDataOutEn(sdoEn),
		.serialChipSelectN(csWire), .pin0Out(p0Out), .pin0OutEn(p0En), .clockoutPinIn(coWire),
		.clockoutPinOut(coOut), .clockoutPinOutEn(coEn), .canResetMode(canResetMode),
		.canWakeIn(canWakeIn), .i2cWake(i2cWake), .hostSpiActive(spiAct), .hostI2cActive(i2cAct),
		.i2cAddressLow(i2cAddr), .systemClockSourceSelect(system_clock_source_select), .externalOscRun(xRun),
		.internalOscRun(iRun), .stopMode(stopMode), .regWrite(regWrite), .regReadAddr(rdAddr),
		.regReadData(~rdAddr)
	);
	shc_spi_master host (.clk(clk), .sck(sck), .mosi(mosi), .csN(csN), .miso(sdoWire));

	////////////////////////////////////////////////////////////////////////
	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// log of register writes and of any data output drive
	always @(posedge clk) begin
		if (regWrite.en === 1'b1) wrLog.push_back(regWrite);
		if (sdoEn === 1'b1) sdoSeen <= 1'b1;
	end

	// clock output rises and last period, counted in system clocks
	always @(posedge clk) begin
		coPrev <= coOut;
		sinceRise <= (coOut && !coPrev) ? 1 : sinceRise + 1;
		if (coOut && !coPrev) begin
			lastPeriod <= sinceRise;
			riseCount <= riseCount + 1;
		end
		// stop bit lands a clock after the write, its pulses reach the pin a clock later still
		ioWrDly <= {ioWrDly[0], regWrite.en === 1'b1 && regWrite.addr === ADDR_IO_CLOCK_CONTROL};
		if (ioWrDly[1]) riseBase <= riseCount;
	end

	////////////////////////////////////////////////////////////////////////
	// a frame of n bytes; logs are cleared so each frame is judged alone
	task automatic frame(input int n, input logic [7:0] b [5], output logic [7:0] r [5]);
		wrLog.delete();
		sdoSeen = 1'b0;
		host.begin_frame();
		for (int i = 0; i < n; i++) host.xfer(b[i], r[i]);
		host.end_frame();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		frame(3, '{INS_WRITE, a, d, 8'h00, 8'h00}, rx);
	endtask
	task automatic uwr(input logic [7:0] a, input logic [7:0] d);
		wr(ADDR_LOCK, UNLOCK_CODE);
		wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		frame(3, '{INS_READ, a, 8'h00, 8'h00, 8'h00}, rx);
	endtask
	task automatic finish_test();
		if (errors == 0 && cmpCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("i2c id", 2'b11, i2cAddr)
		`CHK("port select", 2'b10, {spiAct, i2cAct})
		rd(ADDR_IO_CLOCK_CONTROL);
		`CHK("io_clock_control reset", IO_CLOCK_CONTROL_RESET, rx[2])
		rd(ADDR_GPIO);
		`CHK("gpio reset", GPIO_RESET, rx[2] & 8'hfc)
		// read burst in mode 0, then in mode 3 with the clock idling high
		for (int m = 0; m < 2; m++) begin
			host.set_mode(1'(m));
			frame(4, '{INS_READ, 8'h30, 8'h00, 8'h00, 8'h00}, rx);
			`CHK("read burst", 16'hcfce, {rx[2], rx[3]})
		end
		host.set_mode(1'b0);
		frame(4, '{INS_WRITE, 8'h20, 8'h5a, 8'hc3, 8'h00}, rx);
		`CHK("write count", 2, wrLog.size())
		`CHK("write burst", 32'h205a21c3, {wrLog[0].addr, wrLog[0].data, wrLog[1].addr, wrLog[1].data})
		frame(4, '{8'h55, 8'h20, 8'h5a, 8'hc3, 8'h00}, rx);
		`CHK("unknown ins", 2'b00, {sdoSeen, wrLog.size() != 0})
		// protection: locked, relocked by a foreign write, then unlocked
		wr(ADDR_IO_CLOCK_CONTROL, 8'h01);
		rd(ADDR_IO_CLOCK_CONTROL);
		`CHK("locked write", IO_CLOCK_CONTROL_RESET, rx[2])
		wr(ADDR_LOCK, UNLOCK_CODE);
		wr(8'h20, 8'h00);
		wr(ADDR_IO_CLOCK_CONTROL, 8'h01);
		rd(ADDR_IO_CLOCK_CONTROL);
		`CHK("relock", IO_CLOCK_CONTROL_RESET, rx[2])
		uwr(ADDR_IO_CLOCK_CONTROL, 8'h01);
		rd(ADDR_IO_CLOCK_CONTROL);
		`CHK("osc bits held", 8'h06, rx[2])
		`CHK("pin1 released", 1'b0, coEn)
		// gpio drive, then a five byte bit modify whose tail must be dropped
		wr(ADDR_GPIO, 8'h32);
		`CHK("pin1 drive", 2'b11, {coEn, coOut})
		`CHK("pin0 is select", 1'b0, p0En)
		pinDrive <= 1'b1;
		frame(5, '{INS_MODIFY, ADDR_GPIO, 8'h22, 8'h00, 8'h33}, rx);
		`CHK("modify write", 18'h37910, {wrLog.size() == 1, wrLog[0]})
		rd(ADDR_GPIO);
		`CHK("pin1 input", 8'h12, rx[2] & 8'hfe)
		// every divider code, period in system clocks
		for (int s = 0; s < 4; s++) begin
			uwr(ADDR_IO_CLOCK_CONTROL, {1'b1, 2'(s), 5'h06});
			repeat (40) @(posedge clk);
			`CHK("divider period", 2 << s, lastPeriod)
		end
		// stop mode, woken once by chip select, once by the can path and once by the i2c wake
		canResetMode <= 1'b1;
		for (int w = 0; w < 3; w++) begin
			uwr(ADDR_IO_CLOCK_CONTROL, 8'he7);
			for (int i = 0; i < 1000 && stopMode !== 1'b1; i++) @(posedge clk);
			repeat (20) @(posedge clk);
			`CHK("stop pulses", 16, riseCount - riseBase)
			`CHK("stop pins", 5'b11000, {stopMode, coEn, coOut, xRun, iRun})
			if (w != 0) begin
				canWakeIn <= (w == 1);
				i2cWake   <= (w == 2);
				repeat (6) @(posedge clk);
				canWakeIn <= 1'b0;
				i2cWake   <= 1'b0;
				repeat (4) @(posedge clk);
				`CHK("can or i2c wake", 1'b0, stopMode)
			end
			rd(ADDR_IO_CLOCK_CONTROL);
			`CHK("after wake", 8'he6, rx[2])
			`CHK("osc restart", 2'b11, {xRun, iRun})
		end
		// oscillator selection and enables
		foreach (oscW[i]) begin
			uwr(ADDR_IO_CLOCK_CONTROL, oscW[i]);
			rd(ADDR_IO_CLOCK_CONTROL);
			`CHK("osc control", oscE[i], rx[2])
		end
		`CHK("osc outputs", 3'b110, {system_clock_source_select, xRun, iRun})
		canResetMode <= 1'b0;
		uwr(ADDR_IO_CLOCK_CONTROL, 8'h66);
		rd(ADDR_IO_CLOCK_CONTROL);
		`CHK("osc read only", 8'h6c, rx[2])
		// deselect the serial port: pin0 becomes gpio
		selPin <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("i2c select", 2'b01, {spiAct, i2cAct})
		`CHK("pin0 gpio", 2'b10, {p0En, p0Out})
		selPinB <= 1'b1;
		repeat (6) @(posedge clk);
		`CHK("neither port", 2'b00, {spiAct, i2cAct})
		finish_test();
	end

	// watchdog against a hung frame
	initial begin
		#500us;
		errors++;
		finish_test();
	end
endmodule // tb_shc_host_port
